/* File: wdt_pkg.sv */
package wdt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_RESTART = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;

  // ----------------------------------------------------------------
  // mode register layout and reset value
  // ----------------------------------------------------------------
  localparam int PERIOD_LSB = 0;
  localparam int PERIOD_W = 3;
  localparam int CLK_SEL_LO_BIT = 3;
  localparam int CLK_SEL_HI_BIT = 4;
  localparam logic [7:0] MODE_RESET = 8'h67;

  // ----------------------------------------------------------------
  // restart register codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RESTART_CODE = 8'hac;
  localparam logic [7:0] RESTART_READ = 8'h9a;
  localparam logic [3:0] FULL_STROBE = 4'hf;

  // ----------------------------------------------------------------
  // counter geometry
  // ----------------------------------------------------------------
  localparam int CNT_W = 18;
  localparam logic [4:0] PERIOD_BASE_LOG2 = 5'h0b;

  // ----------------------------------------------------------------
  // event status bits
  // ----------------------------------------------------------------
  localparam int STATUS_W = 3;
  localparam int EV_OVERFLOW = 0;
  localparam int EV_BAD_KEY = 1;
  localparam int EV_REMODE = 2;
  localparam logic [STATUS_W-1:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // wake-up sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_SETTLE = 2'b10
  } wake_state_t;

endpackage

/* File: tick_sync.sv */
`timescale 1ns/1ns
module tick_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_clk,
  output logic tick
);

  // ----------------------------------------------------------------
  // two-stage synchroniser, third stage only for the edge
  // ----------------------------------------------------------------
  logic meta_r, meta_nxt;
  logic sync_r, sync_nxt;
  logic last_r, last_nxt;

  always_comb begin
    meta_nxt = pin_clk;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // one pclk pulse per rising edge of the slow source clock
  assign tick = sync_r & ~last_r;

endmodule

/* File: wd_counter.sv */
`timescale 1ns/1ns
module wd_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic clr,
  input wire logic [2:0] period_sel,
  output logic [wdt_pkg::CNT_W-1:0] count,
  output logic ovf
);

  // ----------------------------------------------------------------
  // period decode
  // ----------------------------------------------------------------
  logic [wdt_pkg::CNT_W:0] span;
  logic [wdt_pkg::CNT_W-1:0] last;
  logic [wdt_pkg::CNT_W-1:0] count_r, count_nxt;
  logic ovf_r, ovf_nxt;

  // each step down halves the period of the longest setting
  always_comb begin
    span = (wdt_pkg::CNT_W+1)'(1) <<
           (wdt_pkg::PERIOD_BASE_LOG2 + 5'(period_sel));
    last = wdt_pkg::CNT_W'(span - (wdt_pkg::CNT_W+1)'(1));
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    ovf_nxt = 1'b0;
    if (clr) begin
      count_nxt = '0;
    end else if (en) begin
      if (count_r == last) begin
        count_nxt = '0;
        ovf_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign count = count_r;
  assign ovf = ovf_r;

  a_period_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en && !clr && count_r == last) |=> (ovf_r && count_r == '0))
    else $error("counter did not wrap at selected period");

endmodule

/* File: wdt_top.sv */
`timescale 1ns/1ns
// Overview of operation
// - count on internal oscillator or crystal clock
// - mode resets to longest period setting
// - counting starts at once on internal oscillator
// - two select bits: oscillator, crystal or stopped
// - low three mode bits pick the period
// - restart code clears counter, counting continues
// - any mode write clears the counter
// - stopped watchdog never raises a reset
// - halt and stop freeze, keep the count
// - crystal wake waits for oscillator settling
// - settle or CPU switch to crystal resumes
// - oscillator-clocked watchdog resumes at wake-up
// - halt freezes counting for every clock pair
// - overflow of running counter raises reset
// - wrong restart value raises reset
// - mode writable once; second write resets
// - restart register reads a fixed value
module wdt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_osc_clk,
  input wire logic xtal_clk,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic cpu_on_xtal,
  input wire logic osc_settled,
  output logic wdt_reset_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // source clock ticks
  // ----------------------------------------------------------------
  logic [1:0] src_pin;
  logic [1:0] src_tick;

  assign src_pin = {xtal_clk, internal_osc_clk};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_src
      tick_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_clk(src_pin[gi]),
        .tick(src_tick[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic mapped;
  logic mode_wr;
  logic restart_wr;
  logic status_rd;
  logic key_good;

  always_comb begin
    access = psel & penable;
    wr = access & pwrite;
    mapped = (paddr == wdt_pkg::ADDR_MODE) ||
             (paddr == wdt_pkg::ADDR_RESTART) ||
             (paddr == wdt_pkg::ADDR_STATUS) ||
             (paddr == wdt_pkg::ADDR_MASK) ||
             (paddr == wdt_pkg::ADDR_COUNT);
    mode_wr = wr & (paddr == wdt_pkg::ADDR_MODE);
    restart_wr = wr & (paddr == wdt_pkg::ADDR_RESTART);
    status_rd = access & ~pwrite & (paddr == wdt_pkg::ADDR_STATUS);
    // a partial-strobe write stands in for a single-bit access
    key_good = (pwdata[7:0] == wdt_pkg::RESTART_CODE) &&
               (pstrb == wdt_pkg::FULL_STROBE);
  end

  // zero wait states: the answer comes in the first access cycle
  assign pready = access;
  assign pslverr = access & ~mapped;

  // ----------------------------------------------------------------
  // mode register and write-once protection
  // ----------------------------------------------------------------
  logic [7:0] mode_r, mode_nxt;
  logic written_r, written_nxt;
  logic stopped_r, stopped_nxt;

  // top mode bits are stored as written; keeping them 011 is up
  // to software and they steer nothing
  always_comb begin
    mode_nxt = mode_r;
    written_nxt = written_r;
    stopped_nxt = stopped_r;
    if (mode_wr && !written_r) begin
      mode_nxt = pwdata[7:0];
      written_nxt = 1'b1;
      // once stopped it never restarts: the register is now locked
      stopped_nxt = pwdata[wdt_pkg::CLK_SEL_HI_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= wdt_pkg::MODE_RESET;
      written_r <= 1'b0;
      stopped_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      written_r <= written_nxt;
      stopped_r <= stopped_nxt;
    end
  end

  // ----------------------------------------------------------------
  // halt / stop / settle sequencing
  // ----------------------------------------------------------------
  wdt_pkg::wake_state_t wake_r, wake_nxt;
  logic wd_xtal_r, wd_xtal_nxt;
  logic cpu_xtal_r, cpu_xtal_nxt;
  logic running;

  always_comb begin
    wake_nxt = wake_r;
    wd_xtal_nxt = wd_xtal_r;
    cpu_xtal_nxt = cpu_xtal_r;
    case (wake_r)
      wdt_pkg::ST_RUN: begin
        if (stop_mode) begin
          wake_nxt = wdt_pkg::ST_STOP;
          wd_xtal_nxt = mode_r[wdt_pkg::CLK_SEL_LO_BIT];
          cpu_xtal_nxt = cpu_on_xtal;
        end
      end
      wdt_pkg::ST_STOP: begin
        if (!stop_mode) begin
          if (wd_xtal_r) begin
            wake_nxt = wdt_pkg::ST_SETTLE;
          end else begin
            wake_nxt = wdt_pkg::ST_RUN;
          end
        end
      end
      wdt_pkg::ST_SETTLE: begin
        // a CPU already on the crystal only waits for settling
        if (osc_settled || (!cpu_xtal_r && cpu_on_xtal)) begin
          wake_nxt = wdt_pkg::ST_RUN;
        end
      end
      default: begin
        wake_nxt = wdt_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= wdt_pkg::ST_RUN;
      wd_xtal_r <= 1'b0;
      cpu_xtal_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
      wd_xtal_r <= wd_xtal_nxt;
      cpu_xtal_r <= cpu_xtal_nxt;
    end
  end

  // halt, stop and settle all freeze the count in place
  assign running = (wake_r == wdt_pkg::ST_RUN) && !halt_mode &&
                   !stop_mode;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic cnt_en;
  logic cnt_clr;
  logic cnt_ovf;
  logic [wdt_pkg::CNT_W-1:0] count;

  always_comb begin
    cnt_en = (mode_r[wdt_pkg::CLK_SEL_LO_BIT] ? src_tick[1]
              : src_tick[0]) & running & ~stopped_r;
    cnt_clr = mode_wr | (restart_wr & key_good);
  end

  wd_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .en(cnt_en),
    .clr(cnt_clr),
    .period_sel(mode_r[wdt_pkg::PERIOD_LSB +: wdt_pkg::PERIOD_W]),
    .count(count),
    .ovf(cnt_ovf)
  );

  // ----------------------------------------------------------------
  // internal reset request
  // ----------------------------------------------------------------
  logic bad_key;
  logic remode;
  logic violation;
  logic pend_r, pend_nxt;
  logic rst_r, rst_nxt;

  always_comb begin
    bad_key = restart_wr & ~key_good;
    remode = mode_wr & written_r;
    violation = (bad_key | remode) & ~stopped_r;
    // a violation while the source is frozen fires on resume
    pend_nxt = (pend_r | violation) & ~running & ~stopped_r;
    rst_nxt = rst_r | cnt_ovf |
              ((violation | pend_r) & running & ~stopped_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      rst_r <= rst_nxt;
    end
  end

  // held until the system reset comes back through presetn
  assign wdt_reset_req = rst_r;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [wdt_pkg::STATUS_W-1:0] ev;
  logic [wdt_pkg::STATUS_W-1:0] status_r, status_nxt;
  logic [wdt_pkg::STATUS_W-1:0] mask_r, mask_nxt;

  always_comb begin
    ev = '0;
    ev[wdt_pkg::EV_OVERFLOW] = cnt_ovf;
    ev[wdt_pkg::EV_BAD_KEY] = bad_key & ~stopped_r;
    ev[wdt_pkg::EV_REMODE] = remode & ~stopped_r;
    // a new event in the reading cycle survives the clear
    status_nxt = (status_rd ? status_r & ~prdata_r[wdt_pkg::STATUS_W-1:0]
                  : status_r) | ev;
    mask_nxt = mask_r;
    if (wr && paddr == wdt_pkg::ADDR_MASK) begin
      mask_nxt = pwdata[wdt_pkg::STATUS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      mask_r <= wdt_pkg::MASK_RESET;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;

  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      case (paddr)
        wdt_pkg::ADDR_MODE: prdata_nxt = {24'h0, mode_r};
        wdt_pkg::ADDR_RESTART: begin
          prdata_nxt = {24'h0, wdt_pkg::RESTART_READ};
        end
        wdt_pkg::ADDR_STATUS: prdata_nxt = {29'h0, status_r};
        wdt_pkg::ADDR_MASK: prdata_nxt = {29'h0, mask_r};
        wdt_pkg::ADDR_COUNT: prdata_nxt = {14'h0, count};
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovf_reset: assert property (
    cnt_ovf |=> wdt_reset_req)
    else $error("overflow did not raise reset");

  a_bad_key_rst: assert property (
    (bad_key && !stopped_r && running) |=> wdt_reset_req)
    else $error("wrong restart value did not raise reset");

  a_stopped_quiet: assert property (
    (stopped_r && !wdt_reset_req) |=> !wdt_reset_req)
    else $error("stopped watchdog raised reset");

  a_mode_clear: assert property (
    mode_wr |=> (count == '0))
    else $error("mode write did not clear counter");

  a_restart_clear: assert property (
    (restart_wr && key_good && !cnt_ovf && !pend_r && !wdt_reset_req)
    |=> (count == '0) ##1 !wdt_reset_req)
    else $error("restart code did not clear counter");

  a_halt_freeze: assert property (
    (halt_mode && !cnt_clr) |=> $stable(count))
    else $error("counter moved during halt");

  a_settle_hold: assert property (
    (wake_r == wdt_pkg::ST_SETTLE && !cnt_clr) |=> $stable(count))
    else $error("counter moved while settling");

  a_osc_wake: assert property (
    (wake_r == wdt_pkg::ST_STOP && !stop_mode && !wd_xtal_r)
    |=> wake_r == wdt_pkg::ST_RUN)
    else $error("oscillator watchdog did not resume");

  a_cpu_switch: assert property (
    (wake_r == wdt_pkg::ST_SETTLE && !cpu_xtal_r && cpu_on_xtal)
    |=> wake_r == wdt_pkg::ST_RUN)
    else $error("cpu switch to crystal did not resume");

  a_restart_read: assert property (
    (access && !pwrite && paddr == wdt_pkg::ADDR_RESTART)
    |-> prdata == {24'h0, wdt_pkg::RESTART_READ})
    else $error("restart register read wrong value");

  a_mode_once: assert property (
    (written_r && mode_wr) |=> $stable(mode_r))
    else $error("mode register changed on second write");

endmodule

/* File: test_stoppable_watchdog_timer.sv */
`timescale 1ns/1ns
module test_stoppable_watchdog_timer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c1;
  logic [3:0] pstrb, div;
  logic osc, xtal, osc_on, xt_on, halt_mode, stop_mode;
  logic cpu_on_xtal, osc_settled, wdt_reset_req, irq;
  int num_errors, checks_done;

  wdt_top i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .internal_osc_clk(osc),
    .xtal_clk(xtal),
    .halt_mode(halt_mode),
    .stop_mode(stop_mode),
    .cpu_on_xtal(cpu_on_xtal),
    .osc_settled(osc_settled),
    .wdt_reset_req(wdt_reset_req),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // clocks: oscillator period 8 pclk, crystal period 4 pclk
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    div <= div + 4'h1;
    if (osc_on && div[1:0] == 2'h3) osc <= ~osc;
    if (xt_on && div[0]) xtal <= ~xtal;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic ok(input logic c, input string m);
    chk({31'h0, c}, 32'h1, m);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // held until pready is seen high; released only after that edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    ok(n == 1, "pready in first access cycle");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdc();
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0, 4'hf);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    wt(6);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_after_reset();
    do_reset();
    apb(1'b0, wdt_pkg::ADDR_MODE, 32'h0, 4'hf);
    chk(rd, 32'h67, "mode after reset");
    apb(1'b0, wdt_pkg::ADDR_RESTART, 32'h0, 4'hf);
    chk(rd, 32'h9a, "restart readback");
    apb(1'b0, 8'h20, 32'h0, 4'hf);
    ok(err === 1'b1 && rd === 32'h0, "unmapped read");
    wt(200);
    rdc();
    ok(rd >= 22 && rd <= 30, "counting on oscillator");
    wt(100);
    wr(wdt_pkg::ADDR_RESTART, 32'hac);
    rdc();
    ok(rd <= 1, "restart clears count");
    wt(40);
    rdc();
    ok(rd >= 3, "counts again after restart");
  endtask

  // every cpu clock / watchdog clock pair freezes in halt
  task automatic t_halt(input logic wd_xt, input logic cpu_xt);
    do_reset();
    cpu_on_xtal <= cpu_xt;
    wr(wdt_pkg::ADDR_MODE, wd_xt ? 32'h6f : 32'h67);
    halt_mode <= 1'b1;
    wt(10);
    rdc();
    c1 = rd;
    wt(100);
    rdc();
    chk(rd, c1, "frozen in halt");
    halt_mode <= 1'b0;
    wt(60);
    rdc();
    ok(rd > c1 && rd < c1 + 32, "resumed after halt");
  endtask

  task automatic t_stop(input logic wd_xt, input logic cpu_xt,
                        input logic sw);
    do_reset();
    cpu_on_xtal <= cpu_xt;
    if (wd_xt) wr(wdt_pkg::ADDR_MODE, 32'h6f);
    stop_mode <= 1'b1;
    wt(20);
    rdc();
    c1 = rd;
    wt(100);
    rdc();
    chk(rd, c1, "frozen in stop");
    stop_mode <= 1'b0;
    if (wd_xt) begin
      wt(100);
      rdc();
      chk(rd, c1, "held while settling");
      if (sw) cpu_on_xtal <= 1'b1;
      else osc_settled <= 1'b1;
      wt(1);
      osc_settled <= 1'b0;
    end
    wt(40);
    rdc();
    ok(rd > c1, "resumed after stop");
  endtask

  task automatic t_overflow(input logic [2:0] sel);
    int n;
    int e;
    do_reset();
    wr(wdt_pkg::ADDR_MASK, 32'h7);
    wr(wdt_pkg::ADDR_MODE, {29'hc, sel});
    e = (2048 << sel) * 8;
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    ok(n >= e - 24 && n <= e + 24, "overflow period");
    ok(irq === 1'b1, "irq on overflow");
    apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h1, "overflow status");
  endtask

  task automatic t_bad_key();
    do_reset();
    wr(wdt_pkg::ADDR_RESTART, 32'h55);
    wt(4);
    ok(wdt_reset_req === 1'b1, "wrong code resets");
    ok(irq === 1'b0, "masked event");
    wr(wdt_pkg::ADDR_MASK, 32'h2);
    ok(irq === 1'b1, "unmasked event");
    apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h2, "bad code status");
    wt(1);
    ok(irq === 1'b0, "cleared by read");
    apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h0, "status empty");
  endtask

  task automatic t_second_mode();
    do_reset();
    wt(200);
    wr(wdt_pkg::ADDR_MODE, 32'h65);
    rdc();
    ok(rd <= 1, "mode write clears count");
    ok(wdt_reset_req === 1'b0, "first mode write");
    wr(wdt_pkg::ADDR_MODE, 32'h62);
    wt(4);
    ok(wdt_reset_req === 1'b1, "second mode write resets");
    apb(1'b0, wdt_pkg::ADDR_MODE, 32'h0, 4'hf);
    chk(rd, 32'h65, "mode kept");
  endtask

  task automatic t_stopped();
    do_reset();
    wr(wdt_pkg::ADDR_MODE, 32'h70);
    wt(100);
    rdc();
    chk(rd, 32'h0, "stopped watchdog");
    wr(wdt_pkg::ADDR_MODE, 32'h67);
    wr(wdt_pkg::ADDR_RESTART, 32'h55);
    apb(1'b1, wdt_pkg::ADDR_RESTART, 32'hac, 4'h1);
    wt(5);
    ok(wdt_reset_req === 1'b0, "no reset while stopped");
    apb(1'b0, wdt_pkg::ADDR_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h0, "no events while stopped");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, osc, xtal} = 6'h0;
    {halt_mode, stop_mode, cpu_on_xtal, osc_settled} = 4'h0;
    {osc_on, xt_on} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    div = 4'h0;
    num_errors = 0;
    checks_done = 0;
    t_after_reset();
    for (int i = 0; i < 4; i++) t_halt(i[1], i[0]);
    t_stop(1'b1, 1'b1, 1'b0);
    t_stop(1'b1, 1'b0, 1'b0);
    t_stop(1'b1, 1'b0, 1'b1);
    t_stop(1'b0, 1'b0, 1'b0);
    t_stop(1'b0, 1'b1, 1'b0);
    t_overflow(3'h0);
    t_overflow(3'h1);
    t_bad_key();
    t_second_mode();
    t_stopped();
    end_sim();
  end

  // the two overflow runs dominate; about 52k cycles in all
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
